/* pkg/dsc_pkg.sv */
package dsc_pkg;

  localparam int RES_W   = 18;
  localparam int RANGE_W = 3;
  localparam int ADDR_W  = 4;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CONFIG  = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_STATUS  = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_RESULT0 = 4'h8;
  localparam logic [ADDR_W-1:0] OFF_RESULT1 = 4'hc;

  // Config layout: {lane2, pwr[1:0], range1[2:0], range0[2:0]}
  localparam int CFG_W         = 9;
  localparam int CFG_LOW_W     = 8;
  localparam int CFG_LANE2_BIT = 8;
  localparam logic [CFG_W-1:0] CFG_RESET = 9'h03f;

  // Status layout
  localparam int STAT_BUSY_BIT    = 0;
  localparam int STAT_VALID_BIT   = 1;
  localparam int STAT_OVERRUN_BIT = 2;

  // Result word layout: {range[2:0], data[17:0]}
  localparam int RESULT_W = RES_W + RANGE_W;

  localparam logic [RANGE_W-1:0] RANGE_DISABLED = 3'h0;
  localparam logic [RANGE_W-1:0] RANGE_WIDEST   = 3'h7;
  localparam logic [RANGE_W-1:0] RANGE_BIP_6    = 3'h6;
  localparam logic [RANGE_W-1:0] RANGE_BIP_3    = 3'h3;
  localparam logic [RANGE_W-1:0] RANGE_BIP_2    = 3'h2;

  localparam logic [1:0] PWR_ACTIVE = 2'h0;
  localparam logic [1:0] PWR_NAP    = 2'h1;
  localparam logic [1:0] PWR_DOWN   = 2'h2;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Cycles from search start to its done pulse
  localparam int SAR_LATENCY = RES_W + 1;

  typedef struct packed {
    logic               lane2;
    logic [1:0]         pwr;
    logic [RANGE_W-1:0] range1;
    logic [RANGE_W-1:0] range0;
  } dsc_cfg_s;

  typedef struct packed {
    logic [RANGE_W-1:0] range;
    logic [RES_W-1:0]   data;
  } dsc_result_s;

  typedef enum logic [2:0] {ST_TRACK, ST_HOLD, ST_CONV0, ST_CONV1, ST_FORMAT} dsc_state_e;

  function automatic logic dsc_is_bipolar(input logic [RANGE_W-1:0] code);
    return (code == RANGE_WIDEST) || (code == RANGE_BIP_6) || (code == RANGE_BIP_3) || (code == RANGE_BIP_2);
  endfunction

endpackage

/* rtl/dsc_sar.sv */
`timescale 1ns/1ps
module dsc_sar
  import dsc_pkg::*;
#(
  parameter int WIDTH = RES_W
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             start,
  input  wire logic             cmp_above,
  output logic [WIDTH-1:0]      code,
  output logic                  done
);

  localparam logic [WIDTH-1:0] MSB_ONE = {1'b1, {(WIDTH-1){1'b0}}};

  logic [WIDTH-1:0] mask;
  wire  [WIDTH-1:0] next_code;

  // Keep the trial bit if the held sample is above it, then try the next lower weight
  assign next_code = (cmp_above ? code : (code & ~mask)) | (mask >> 1);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      code <= '0;
      mask <= '0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        code <= MSB_ONE;
        mask <= MSB_ONE;
      end else if (mask != '0) begin
        code <= next_code;
        mask <= mask >> 1;
        done <= mask[0];
      end
    end
  end

endmodule

/* rtl/dsc_top.sv */
// Behaviour
// - A rising convert_trigger edge puts both channels into hold together and starts conversion.
// - While converting, one held channel at a time drives the single shared 18-bit DAC.
// - Each channel is resolved by an 18-step binary search from half scale down to one 262144th.
// - Output codes are prepared only after both channels have finished their search.
// - Every channel result word carries 18 data bits, one of 2^18 codes, below its 3-bit range code.
// - Bipolar range codes give two's complement results, unipolar ones straight binary.
// - Each channel's range code is taken per conversion and applied independently.
// - Range code 7 is the widest bipolar span and gives two's complement.
// - A channel whose range code disables it is skipped, shortening the conversion.
// - Each held sample is cleared after its conversion, so tracking resumes before the next trigger.
// - The host may select one or two serial output lanes.
// - Nap and power-down states reduce consumption while idle.
// - The two 3-bit range codes form the low 6 bits of the 9-bit configuration word written by the host.
// - Range codes 7, 6, 3 and 2 are bipolar and give two's complement.
// - Range codes 5, 4 and 1 are unipolar and give straight binary.
//
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module dsc_top
  import dsc_pkg::*;
#(
  parameter int ADDR_WIDTH = ADDR_W
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  convert_trigger,
  input  wire logic                  cmp_above,
  input  wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output logic                       track_hold,
  output logic                       dac_chan,
  output logic [RES_W-1:0]           charge_redistribution_dac_code,
  output logic [1:0]                 sample_clear,
  output dsc_result_s                result0,
  output dsc_result_s                result1,
  output logic                       results_valid,
  output logic                       lane2,
  output logic                       nap_active,
  output logic                       power_down
);

  dsc_state_e        state;
  dsc_state_e        next_state;
  dsc_cfg_s          cfg;
  dsc_cfg_s          conv_cfg;
  logic [2:0]        trig_sync;
  logic              trig_level;
  logic              overrun;
  logic [RES_W-1:0]  raw0;
  logic [RES_W-1:0]  raw1;
  logic              sar_done;
  logic [RES_W-1:0]  sar_code;

  // Register bus holding registers
  logic [ADDR_WIDTH-1:0] aw_addr;
  logic                  aw_held;
  logic [31:0]           w_data;
  logic [3:0]            w_strb;
  logic                  w_held;

  wire trig_rise;
  wire accept;
  wire ovr_set;
  wire ovr_clr;
  wire sar_start;
  wire busy;
  wire wr_fire;
  wire wr_cfg;
  wire wr_stat;
  wire wr_known;
  wire rd_known;
  wire [CFG_W-1:0] next_cfg;
  wire [31:0]      rd_word;

  // Trigger pin: a level counts once the second and third stages agree
  assign trig_rise = trig_sync[1] & trig_sync[2] & ~trig_level;
  assign busy      = (state != ST_TRACK);
  // Power-down refuses triggers; nap is left by the trigger itself
  assign accept    = trig_rise && !busy && (cfg.pwr != PWR_DOWN);
  assign ovr_set   = trig_rise && busy;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trig_sync  <= 3'h0;
      trig_level <= 1'b0;
    end else begin
      trig_sync <= {trig_sync[1:0], convert_trigger};
      if (trig_sync[1] == trig_sync[2]) begin
        trig_level <= trig_sync[2];
      end
    end
  end

  // Conversion sequencing
  always_comb begin
    next_state = state;
    case (state)
      ST_TRACK: begin
        if (accept) begin
          next_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (conv_cfg.range0 != RANGE_DISABLED) begin
          next_state = ST_CONV0;
        end else if (conv_cfg.range1 != RANGE_DISABLED) begin
          next_state = ST_CONV1;
        end else begin
          next_state = ST_FORMAT;
        end
      end
      ST_CONV0: begin
        if (sar_done) begin
          next_state = (conv_cfg.range1 != RANGE_DISABLED) ? ST_CONV1 : ST_FORMAT;
        end
      end
      ST_CONV1: begin
        if (sar_done) begin
          next_state = ST_FORMAT;
        end
      end
      ST_FORMAT: begin
        next_state = ST_TRACK;
      end
      default: begin
        next_state = ST_TRACK;
      end
    endcase
  end

  assign sar_start = (next_state != state) && ((next_state == ST_CONV0) || (next_state == ST_CONV1));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ST_TRACK;
    end else begin
      state <= next_state;
    end
  end

  // Range codes are frozen at the trigger so a config write mid-conversion cannot mix formats
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      conv_cfg <= dsc_cfg_s'(CFG_RESET);
    end else if (accept) begin
      conv_cfg <= cfg;
    end
  end

  dsc_sar #(
    .WIDTH (RES_W)
  ) u_sar (
    .clk       (clk),
    .rst       (rst),
    .start     (sar_start),
    .cmp_above (cmp_above),
    .code      (sar_code),
    .done      (sar_done)
  );

  assign charge_redistribution_dac_code = sar_code;
  assign track_hold = busy;
  assign dac_chan   = (state == ST_CONV1);
  assign lane2      = cfg.lane2;
  assign nap_active = !busy && (cfg.pwr == PWR_NAP);
  assign power_down = !busy && (cfg.pwr == PWR_DOWN);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      raw0         <= '0;
      raw1         <= '0;
      sample_clear <= 2'h0;
    end else begin
      sample_clear <= {sar_done && (state == ST_CONV1), sar_done && (state == ST_CONV0)};
      if (sar_done && (state == ST_CONV0)) begin
        raw0 <= sar_code;
      end
      if (sar_done && (state == ST_CONV1)) begin
        raw1 <= sar_code;
      end
    end
  end

  // Search yields offset binary; flipping the top bit gives two's complement
  function automatic logic [RES_W-1:0] fmt(input logic [RES_W-1:0] raw, input logic [RANGE_W-1:0] rng);
    if (rng == RANGE_DISABLED) begin
      return '0;
    end else if (dsc_is_bipolar(rng)) begin
      return {~raw[RES_W-1], raw[RES_W-2:0]};
    end else begin
      return raw;
    end
  endfunction

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result0       <= '0;
      result1       <= '0;
      results_valid <= 1'b0;
    end else if (state == ST_FORMAT) begin
      result0       <= '{range: conv_cfg.range0, data: fmt(raw0, conv_cfg.range0)};
      result1       <= '{range: conv_cfg.range1, data: fmt(raw1, conv_cfg.range1)};
      results_valid <= 1'b1;
    end else if (accept) begin
      results_valid <= 1'b0;
    end
  end

  // Register bus: write address and data are caught in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire  = aw_held && w_held && !s_axi_bvalid;
  assign wr_cfg   = wr_fire && (aw_addr == OFF_CONFIG);
  assign wr_stat  = wr_fire && (aw_addr == OFF_STATUS);
  assign wr_known = (aw_addr == OFF_CONFIG) || (aw_addr == OFF_STATUS);
  assign rd_known = (s_axi_araddr == OFF_CONFIG) || (s_axi_araddr == OFF_STATUS) ||
                    (s_axi_araddr == OFF_RESULT0) || (s_axi_araddr == OFF_RESULT1);
  assign next_cfg = {(wr_cfg && w_strb[1]) ? w_data[CFG_LANE2_BIT] : cfg.lane2,
                     (wr_cfg && w_strb[0]) ? w_data[CFG_LOW_W-1:0] : cfg[CFG_LOW_W-1:0]};
  assign ovr_clr  = wr_stat && w_strb[0] && w_data[STAT_OVERRUN_BIT];
  assign rd_word  = (s_axi_araddr == OFF_CONFIG)  ? {{(32-CFG_W){1'b0}}, cfg} :
                    (s_axi_araddr == OFF_STATUS)  ? {29'h0, overrun, results_valid, busy} :
                    (s_axi_araddr == OFF_RESULT0) ? {{(32-RESULT_W){1'b0}}, result0} :
                    (s_axi_araddr == OFF_RESULT1) ? {{(32-RESULT_W){1'b0}}, result1} : 32'h0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
      w_held  <= 1'b0;
      w_data  <= 32'h0;
      w_strb  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= RESP_OKAY;
      s_axi_rdata  <= 32'h0;
    end else begin
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? RESP_OKAY : RESP_DECERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_known ? RESP_OKAY : RESP_DECERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Overrun: a trigger refused while busy in the clearing cycle still sets it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg     <= dsc_cfg_s'(CFG_RESET);
      overrun <= 1'b0;
    end else begin
      cfg     <= dsc_cfg_s'(next_cfg);
      overrun <= ovr_set | (overrun & ~ovr_clr);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence trig_taken_s;
    accept;
  endsequence

  sequence search_run_s;
    sar_start ##19 sar_done;
  endsequence

  hold_on_trigger_a: assert property (trig_taken_s |=> track_hold && (state == ST_HOLD))
    else $error("Accepted trigger did not enter hold");

  one_channel_dac_a: assert property (sar_done && (state == ST_CONV0) && (conv_cfg.range1 != RANGE_DISABLED)
                                      |=> dac_chan ##18 sar_done)
    else $error("Channel 1 not converted after channel 0");

  search_length_a: assert property (sar_start |-> ##19 sar_done)
    else $error("Search did not take 18 steps");

  search_quiet_a: assert property (sar_start |=> !sar_done [*8])
    else $error("Search finished early");

  ready_after_both_a: assert property ($rose(results_valid) |-> $past(state) == ST_FORMAT)
    else $error("Results ready before both searches");

  bipolar_format_a: assert property ((state == ST_FORMAT) && dsc_is_bipolar(conv_cfg.range0) |=>
                                     result0.data[RES_W-1] != raw0[RES_W-1])
    else $error("Bipolar result not two's complement");

  unipolar_format_a: assert property ((state == ST_FORMAT) && (conv_cfg.range1 != RANGE_DISABLED) &&
                                      !dsc_is_bipolar(conv_cfg.range1) |=> result1.data == raw1)
    else $error("Unipolar result not straight binary");

  skip_disabled_a: assert property ((state == ST_HOLD) && (conv_cfg.range0 == RANGE_DISABLED) |=>
                                    state != ST_CONV0)
    else $error("Disabled channel was converted");

  clear_after_conv_a: assert property (sar_done && (state == ST_CONV0) |=> sample_clear == 2'h1)
    else $error("Held sample not cleared");

  ignore_busy_trig_a: assert property (trig_rise && busy |=> $stable(conv_cfg) && overrun)
    else $error("Trigger during conversion not ignored");

  range_frozen_a: assert property (trig_taken_s |=> conv_cfg == $past(cfg))
    else $error("Range codes not taken at trigger");

endmodule

/* verification/dsc_analog_model.sv */
`timescale 1ns/1ps
module dsc_analog_model
  import dsc_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             track_hold,
  input  wire logic             dac_chan,
  input  wire logic [RES_W-1:0] dac_code,
  input  wire logic [1:0]       sample_clear,
  input  wire logic [RES_W-1:0] in0,
  input  wire logic [RES_W-1:0] in1,
  output logic                  cmp_above
);
  logic [RES_W-1:0] held0;
  logic [RES_W-1:0] held1;
  logic             hold_q;
  logic             toggle;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_q <= 1'b0;
      toggle <= 1'b0;
      held0  <= '0;
      held1  <= '0;
    end else begin
      hold_q <= track_hold;
      toggle <= ~toggle;
      if (track_hold && !hold_q) begin
        held0 <= in0;
        held1 <= in1;
      end
      if (sample_clear[0]) held0 <= '0;
      if (sample_clear[1]) held1 <= '0;
    end
  end
  // Toggles while tracking so a search outside a hold cannot pass by luck
  assign cmp_above = !track_hold ? toggle : dac_chan ? (held1 >= dac_code) : (held0 >= dac_code);
endmodule

/* verification/dual_sar_conversion_control_bench.sv */
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin \
  error_cnt++; $display("[ERR] %s exp %h got %h", nm, exp, got); end end
module dual_sar_conversion_control_bench
  import dsc_pkg::*;
;
  typedef struct packed {
    logic [2:0]  r0;
    logic [2:0]  r1;
    logic [17:0] s0;
    logic [17:0] s1;
    logic [17:0] e0;
    logic [17:0] e1;
  } dsc_row_s;
  logic              clk, rst, convert_trigger, cmp_above;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp, resp, clr;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic              track_hold, dac_chan, results_valid, lane2, nap_active, power_down, seen1;
  logic [RES_W-1:0]  dac_code, in0, in1;
  dsc_result_s       result0, result1;
  dsc_cfg_s          cfg;
  logic [1:0]        sample_clear_w;
  int                error_cnt, n_checks, cycles, n, nb;
  // Bipolar codes flip the top bit of the raw result, code 0 reads as zeros
  dsc_row_s          rows [8] = '{
    '{3'h7, 3'h5, 18'h2abcd, 18'h1357b, 18'h0abcd, 18'h1357b},
    '{3'h6, 3'h4, 18'h0abcd, 18'h3357b, 18'h2abcd, 18'h3357b},
    '{3'h3, 3'h1, 18'h3ffff, 18'h00000, 18'h1ffff, 18'h00000},
    '{3'h2, 3'h0, 18'h00000, 18'h12345, 18'h20000, 18'h00000},
    '{3'h1, 3'h3, 18'h3ffff, 18'h00001, 18'h3ffff, 18'h20001},
    '{3'h0, 3'h2, 18'h11111, 18'h3fffe, 18'h00000, 18'h1fffe},
    '{3'h4, 3'h6, 18'h20000, 18'h1ffff, 18'h20000, 18'h3ffff},
    '{3'h5, 3'h7, 18'h00001, 18'h3ffff, 18'h00001, 18'h1ffff}};

  dsc_top dsc_top_i (
    .clk(clk), .rst(rst), .convert_trigger(convert_trigger), .cmp_above(cmp_above),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .track_hold(track_hold),
    .dac_chan(dac_chan), .charge_redistribution_dac_code(dac_code), .sample_clear(sample_clear_w),
    .result0(result0), .result1(result1), .results_valid(results_valid), .lane2(lane2),
    .nap_active(nap_active), .power_down(power_down)
  );
  dsc_analog_model dsc_analog_model_i (
    .clk(clk), .rst(rst), .track_hold(track_hold), .dac_chan(dac_chan), .dac_code(dac_code),
    .sample_clear(sample_clear_w), .in0(in0), .in1(in1), .cmp_above(cmp_above)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, tb;
    tb = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!tb) begin
      @(negedge clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid && s_axi_bready;
      r = s_axi_bresp;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) s_axi_bready <= 1'b0;
    end
  endtask

  task automatic axi_read(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    tr = 1'b0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!tr) begin
      @(negedge clk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid && s_axi_rready;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) s_axi_rready <= 1'b0;
    end
  endtask

  // Trigger held for several cycles so the input synchroniser sees a clean edge
  task automatic convert(input bit retrig);
    logic busy;
    busy = 1'b0;
    clr = 2'b00;
    seen1 = 1'b0;
    @(posedge clk);
    convert_trigger <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(negedge clk);
      busy = busy | track_hold;
      clr = clr | sample_clear_w;
      seen1 = seen1 | (track_hold & dac_chan);
      if (busy && results_valid) break;
      @(posedge clk);
      if (n == 5 || n == 25) convert_trigger <= 1'b0;
      if (n == 20 && retrig) convert_trigger <= 1'b1;
    end
  endtask

  task automatic reset_and_check();
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    `CHK("idle outputs", 5'h0, {track_hold, results_valid, lane2, nap_active, power_down})
    axi_read(OFF_CONFIG, rd, resp);
    `CHK("config", {23'h0, CFG_RESET}, rd)
    axi_read(OFF_STATUS, rd, resp);
    `CHK("status", 32'h0, rd)
    $display("test reset done");
  endtask

  initial begin
    rst = 1'b1;
    convert_trigger = 1'b0;
    in0 = '0;
    in1 = '0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    reset_and_check();
    for (int i = 0; i < 8; i++) begin
      cfg = '{lane2: i[0], pwr: PWR_ACTIVE, range1: rows[i].r1, range0: rows[i].r0};
      axi_write(OFF_CONFIG, {23'h0, cfg}, resp);
      in0 <= rows[i].s0;
      in1 <= rows[i].s1;
      convert(1'b0);
      `CHK("result0", {rows[i].r0, rows[i].e0}, result0)
      `CHK("result1", {rows[i].r1, rows[i].e1}, result1)
      axi_read(OFF_RESULT0, rd, resp);
      `CHK("result0 read", {11'h0, rows[i].r0, rows[i].e0}, rd)
      `CHK("lane2", i[0], lane2)
      `CHK("ch1 on dac", rows[i].r1 != 3'h0, seen1)
      if (rows[i].r0 != 3'h0 && rows[i].r1 != 3'h0) begin
        `CHK("clears", 2'b11, clr)
        nb = n;
      end else begin
        `CHK("skip shorter", 1'b1, n + SAR_LATENCY <= nb + 1)
      end
      $display("test row %0d done", i);
    end
    convert(1'b1);
    `CHK("result1 kept", {rows[7].r1, rows[7].e1}, result1)
    repeat (10) @(negedge clk);
    `CHK("no restart", 2'b01, {track_hold, results_valid})
    axi_read(OFF_STATUS, rd, resp);
    `CHK("overrun", 32'h6, rd)
    axi_write(OFF_STATUS, 32'h4, resp);
    axi_read(OFF_STATUS, rd, resp);
    `CHK("overrun cleared", 32'h2, rd)
    $display("test overrun done");
    axi_write(4'h2, 32'h0, resp);
    `CHK("write decerr", RESP_DECERR, resp)
    axi_read(4'h2, rd, resp);
    `CHK("read decerr", {RESP_DECERR, 32'h0}, {resp, rd})
    axi_read(OFF_CONFIG, rd, resp);
    `CHK("config kept", {23'h0, cfg}, rd)
    $display("test unmapped done");
    cfg.pwr = PWR_NAP;
    axi_write(OFF_CONFIG, {23'h0, cfg}, resp);
    @(negedge clk);
    `CHK("nap", 2'b10, {nap_active, power_down})
    convert(1'b0);
    `CHK("nap wakes", 1'b1, n < 200)
    cfg.pwr = PWR_DOWN;
    axi_write(OFF_CONFIG, {23'h0, cfg}, resp);
    @(negedge clk);
    `CHK("down", 2'b01, {nap_active, power_down})
    convert(1'b0);
    `CHK("down refuses", 200, n)
    $display("test power done");
    reset_and_check();
    report_and_stop();
  end
endmodule
